// >>> src/dpm_ctrl.sv
// Purpose: DAC path and mixer control register bank with decoded controls
// Assumes: Single 100 MHz clock; mute status pin is asynchronous
// Notes:   Every output is registered, so decoded controls lag the write by one, channel sources by two or three
//
// Implementation choice: the Avalon-MM register port.
module dpm_ctrl (
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        GLOBAL_MUTE_STATE,
  input  wire logic        SAMPLE_VALID,
  input  wire logic [23:0] SAMPLE_DATA,
  output logic             OUTPUT_POLARITY_INVERT,
  output logic             SHAPER_ORDER_SELECT,
  output logic             MIX_ENABLE,
  output logic             MIX_AFTER_PROC,
  output logic             MIX_BYPASS,
  output logic             MIX_SIG_ATTEN_6DB,
  output logic             BASS_RESONANT,
  output logic      [2:0]  CHAN_A_SOURCE,
  output logic      [2:0]  CHAN_B_SOURCE,
  output logic      [3:0]  CHAN_A_DEEMPH,
  output logic      [3:0]  CHAN_B_DEEMPH,
  output logic      [1:0]  OS_SPEED,
  output logic             VOLUME_ALLOWED,
  output logic             QUIET_DETECTED,
  output logic             SILENCE_SWITCH,
  output logic             IRQ
);

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  dpm_pkg::dpm_ctrl_t            ctrl_r;
  dpm_pkg::dpm_ctrl_t            ctrl_nxt;
  dpm_pkg::dpm_aux_t             aux_r;
  dpm_pkg::dpm_aux_t             aux_nxt;
  logic [dpm_pkg::IRQ_W-1:0]     stat_r;
  logic [dpm_pkg::IRQ_W-1:0]     stat_nxt;
  logic [dpm_pkg::IRQ_W-1:0]     mask_r;
  logic [dpm_pkg::IRQ_W-1:0]     mask_nxt;
  wire  [dpm_pkg::IRQ_W-1:0]     evt;
  logic [dpm_pkg::SYNC_LEN-1:0]  mute_sync_r;
  logic                          mute_r;
  dpm_pkg::dpm_src_t             src_a_r;
  dpm_pkg::dpm_src_t             src_b_r;
  dpm_pkg::dpm_src_t             src_a_req;
  dpm_pkg::dpm_src_t             src_b_req;
  logic                          wait_r;
  logic [31:0]                   rdata_r;
  logic [31:0]                   rdata_nxt;
  logic                          quiet;
  logic                          quiet_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the access completes

  wire req      = AVS_READ || AVS_WRITE;
  wire accept   = req && wait_r;
  wire wr_do    = AVS_WRITE && !wait_r;
  wire sel_ctrl = (AVS_ADDRESS == dpm_pkg::ADDR_CTRL);
  wire sel_aux  = (AVS_ADDRESS == dpm_pkg::ADDR_AUX);
  wire sel_stat = (AVS_ADDRESS == dpm_pkg::ADDR_STAT);
  wire sel_mask = (AVS_ADDRESS == dpm_pkg::ADDR_MASK);
  wire sel_info = (AVS_ADDRESS == dpm_pkg::ADDR_INFO);
  wire be0      = AVS_BYTEENABLE[0];
  wire be1      = AVS_BYTEENABLE[1];

  // Byte lanes merged per lane; unmapped writes are dropped
  wire [15:0] ctrl_wr = {be1 ? AVS_WRITEDATA[15:8] : ctrl_r[15:8],
                         be0 ? AVS_WRITEDATA[7:0]  : ctrl_r[7:0]};

  assign ctrl_nxt = (wr_do && sel_ctrl) ? dpm_pkg::dpm_ctrl_t'(ctrl_wr) : ctrl_r;
  assign aux_nxt  = (wr_do && sel_aux && be0) ? dpm_pkg::dpm_aux_t'(AVS_WRITEDATA[6:0]) : aux_r;
  assign mask_nxt = (wr_do && sel_mask && be0) ? AVS_WRITEDATA[dpm_pkg::IRQ_W-1:0] : mask_r;

  // Set wins over a write-one clear in the same cycle
  wire [dpm_pkg::IRQ_W-1:0] w1c = (wr_do && sel_stat && be0) ?
                                  AVS_WRITEDATA[dpm_pkg::IRQ_W-1:0] : '0;
  assign stat_nxt = (stat_r & ~w1c) | evt;

  wire [31:0] info_word = {22'h0, mute_r, quiet, src_b_r, src_a_r, OS_SPEED};

  assign rdata_nxt = sel_ctrl ? {16'h0, ctrl_r} :
                     sel_aux  ? {25'h0, aux_r} :
                     sel_stat ? {28'h0, stat_r} :
                     sel_mask ? {28'h0, mask_r} :
                     sel_info ? info_word : 32'h0;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wait_r  <= !accept;
      rdata_r <= accept ? rdata_nxt : rdata_r;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_r <= dpm_pkg::CTRL_RST;
      aux_r  <= dpm_pkg::AUX_RST;
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      aux_r  <= aux_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mute status pin synchroniser

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      mute_sync_r <= '0;
      mute_r      <= 1'b0;
    end else begin
      mute_sync_r <= {mute_sync_r[1:0], GLOBAL_MUTE_STATE};
      if (mute_sync_r[1] == mute_sync_r[2]) begin
        mute_r <= mute_sync_r[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mixer and oversampling decode

  wire os_single = (ctrl_r.oversample_input_mode == dpm_pkg::OS_SINGLE);
  wire os_quad   = (ctrl_r.oversample_input_mode == dpm_pkg::OS_QUAD);
  wire os_rsvd   = (ctrl_r.oversample_input_mode == dpm_pkg::OS_RSVD);
  // Reserved speed code is treated as single speed so audio keeps flowing
  wire mix_ok    = ctrl_r.mix_enable && (os_single || os_rsvd);
  wire atten_nxt = mix_ok && !aux_r.mix_gain_select;
  wire vol_nxt   = !os_quad;
  wire [1:0] os_nxt = os_rsvd ? dpm_pkg::OS_SINGLE : ctrl_r.oversample_input_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel source and de-emphasis decode

  logic [1:0] src_code [2];
  logic [2:0] de_code  [2];
  logic [3:0] de_oh    [2];
  dpm_pkg::dpm_src_t src_dec [2];

  assign src_code[0] = ctrl_r.chan_a_source_select;
  assign src_code[1] = ctrl_r.chan_b_source_select;
  assign de_code[0]  = aux_r.chan_a_deemph_setting;
  assign de_code[1]  = aux_r.chan_b_deemph_setting;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      assign src_dec[ch] = (src_code[ch] == dpm_pkg::SRC_CODE_ADC) ? dpm_pkg::DPM_SRC_ADC :
                           (src_code[ch] == dpm_pkg::SRC_CODE_IEC) ? dpm_pkg::DPM_SRC_IEC :
                           dpm_pkg::DPM_SRC_I2S;
      // Undefined codes leave de-emphasis off
      assign de_oh[ch] = (de_code[ch] == dpm_pkg::DE_CODE_32K) ? dpm_pkg::DE_OH_32K :
                         (de_code[ch] == dpm_pkg::DE_CODE_44K) ? dpm_pkg::DE_OH_44K :
                         (de_code[ch] == dpm_pkg::DE_CODE_48K) ? dpm_pkg::DE_OH_48K :
                         (de_code[ch] == dpm_pkg::DE_CODE_96K) ? dpm_pkg::DE_OH_96K :
                         dpm_pkg::DE_OH_OFF;
    end
  endgenerate

  // Channel B follows only once channel A already carries its request
  wire a_valid = (src_a_r == src_dec[0]);
  assign src_a_req = mix_ok ? src_dec[0] : src_a_r;
  assign src_b_req = (mix_ok && a_valid) ? src_dec[1] : src_b_r;
  wire src_chg = (src_a_req != src_a_r) || (src_b_req != src_b_r);

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      src_a_r <= dpm_pkg::SRC_A_RST;
      src_b_r <= dpm_pkg::SRC_B_RST;
    end else begin
      src_a_r <= src_a_req;
      src_b_r <= src_b_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Silence detection and switch

  dpm_quiet_det u_quiet (
    .clk          (CLK_SYS),
    .rst          (SYS_RST),
    .enable       (ctrl_r.quiet_detector_enable),
    .thresh_sel   (ctrl_r.quiet_threshold_select),
    .sample_valid (SAMPLE_VALID),
    .sample_zero  (SAMPLE_DATA == {dpm_pkg::SAMPLE_W{1'b0}}),
    .quiet        (quiet)
  );

  // Override forces the switch; beware the offset step this causes
  wire switch_nxt = ctrl_r.quiet_override || quiet || mute_r;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      quiet_d_r <= 1'b0;
    end else begin
      quiet_d_r <= quiet;
    end
  end

  assign evt[dpm_pkg::IRQ_QUIET_ON] = quiet && !quiet_d_r;
  assign evt[dpm_pkg::IRQ_QUIET_OF] = !quiet && quiet_d_r;
  // Flag any control write that selects the reserved speed code
  assign evt[dpm_pkg::IRQ_OS_RSVD]  = wr_do && sel_ctrl &&
                                      (ctrl_nxt.oversample_input_mode == dpm_pkg::OS_RSVD);
  assign evt[dpm_pkg::IRQ_SRC_CHG]  = src_chg;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      OUTPUT_POLARITY_INVERT <= 1'b0;
      SHAPER_ORDER_SELECT    <= 1'b0;
      MIX_ENABLE             <= 1'b0;
      MIX_AFTER_PROC         <= 1'b0;
      MIX_BYPASS             <= 1'b0;
      MIX_SIG_ATTEN_6DB      <= 1'b0;
      BASS_RESONANT          <= 1'b0;
      CHAN_A_SOURCE          <= 3'h0;
      CHAN_B_SOURCE          <= 3'h0;
      CHAN_A_DEEMPH          <= 4'h0;
      CHAN_B_DEEMPH          <= 4'h0;
      OS_SPEED               <= 2'h0;
      VOLUME_ALLOWED         <= 1'b0;
      QUIET_DETECTED         <= 1'b0;
      SILENCE_SWITCH         <= 1'b0;
      IRQ                    <= 1'b0;
    end else begin
      OUTPUT_POLARITY_INVERT <= ctrl_r.output_polarity_invert;
      SHAPER_ORDER_SELECT    <= ctrl_r.shaper_order_select;
      MIX_ENABLE             <= mix_ok;
      MIX_AFTER_PROC         <= ctrl_r.mix_after_proc;
      MIX_BYPASS             <= ctrl_r.mix_bypass;
      MIX_SIG_ATTEN_6DB      <= atten_nxt;
      BASS_RESONANT          <= ctrl_r.bass_resonant;
      CHAN_A_SOURCE          <= src_a_r;
      CHAN_B_SOURCE          <= src_b_r;
      CHAN_A_DEEMPH          <= de_oh[0];
      CHAN_B_DEEMPH          <= de_oh[1];
      OS_SPEED               <= os_nxt;
      VOLUME_ALLOWED         <= vol_nxt;
      QUIET_DETECTED         <= quiet;
      SILENCE_SWITCH         <= switch_nxt;
      IRQ                    <= |(stat_r & mask_r);
    end
  end

  assign AVS_READDATA    = rdata_r;
  assign AVS_WAITREQUEST = wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_atten_gain_low: assert property (
    (ctrl_r.mix_enable && os_single && !aux_r.mix_gain_select) |=> MIX_SIG_ATTEN_6DB)
    else $error("mixer signal not cut 6 dB");

  a_atten_gain_high: assert property (
    (ctrl_r.mix_enable && aux_r.mix_gain_select) |=> !MIX_SIG_ATTEN_6DB)
    else $error("mixer signal cut with gain select set");

  a_deemph_48k: assert property (
    (aux_r.chan_b_deemph_setting == dpm_pkg::DE_CODE_48K) |=> (CHAN_B_DEEMPH == dpm_pkg::DE_OH_48K))
    else $error("channel B de-emphasis decode wrong");

  a_polarity_follow: assert property (
    $changed(ctrl_r.output_polarity_invert) |=> (OUTPUT_POLARITY_INVERT == $past(ctrl_r.output_polarity_invert)))
    else $error("polarity output did not follow control");

  a_src_frozen: assert property (
    !ctrl_r.mix_enable |=> $stable(src_a_r) && $stable(src_b_r))
    else $error("source changed with mixer off");

  a_src_b_waits: assert property (
    (src_a_r != src_dec[0]) |=> $stable(src_b_r))
    else $error("channel B moved before channel A valid");

  a_override_force: assert property (
    ctrl_r.quiet_override |=> SILENCE_SWITCH)
    else $error("override did not force silence switch");

  a_switch_follow: assert property (
    !ctrl_r.quiet_override |=> (SILENCE_SWITCH == ($past(quiet) || $past(mute_r))))
    else $error("silence switch not following detector and mute");

  a_quiet_disabled: assert property (
    (!ctrl_r.quiet_detector_enable)[*2] |=> !QUIET_DETECTED)
    else $error("silence flagged while detector disabled");

  a_wait_once: assert property (
    (req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("waitrequest not low for exactly one cycle");

  a_irq_level: assert property (
    (|(stat_r & mask_r)) |=> IRQ)
    else $error("interrupt not raised for unmasked status");

endmodule

// >>> src/dpm_pkg.sv
// Purpose: Shared constants and types for the DAC path and mixer control block
// Assumes: Avalon-MM register slave, byte addresses, 32-bit data words
// Notes:   Control word keeps the documented 16-bit layout in the low half
package dpm_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [7:0] ADDR_AUX  = 8'h20;
  localparam logic [7:0] ADDR_STAT = 8'h24;
  localparam logic [7:0] ADDR_MASK = 8'h28;
  localparam logic [7:0] ADDR_INFO = 8'h2c;

  typedef struct packed {
    logic       output_polarity_invert;
    logic       shaper_order_select;
    logic       mix_after_proc;
    logic       mix_enable;
    logic [1:0] chan_b_source_select;
    logic [1:0] chan_a_source_select;
    logic       quiet_override;
    logic       quiet_detector_enable;
    logic [1:0] quiet_threshold_select;
    logic       bass_resonant;
    logic       mix_bypass;
    logic [1:0] oversample_input_mode;
  } dpm_ctrl_t;

  typedef struct packed {
    logic       mix_gain_select;
    logic [2:0] chan_b_deemph_setting;
    logic [2:0] chan_a_deemph_setting;
  } dpm_aux_t;

  localparam dpm_ctrl_t CTRL_RST = 16'h4d00;
  localparam dpm_aux_t  AUX_RST  = 7'h00;

  // Source field codes; 01 and 11 both mean the serial audio input
  localparam logic [1:0] SRC_CODE_ADC = 2'h0;
  localparam logic [1:0] SRC_CODE_IEC = 2'h2;

  typedef enum logic [2:0] {
    DPM_SRC_ADC = 3'h1,
    DPM_SRC_I2S = 3'h2,
    DPM_SRC_IEC = 3'h4
  } dpm_src_t;

  localparam dpm_src_t SRC_A_RST = DPM_SRC_I2S;
  localparam dpm_src_t SRC_B_RST = DPM_SRC_I2S;

  // Oversampling input modes
  localparam logic [1:0] OS_SINGLE = 2'h0;
  localparam logic [1:0] OS_DOUBLE = 2'h1;
  localparam logic [1:0] OS_QUAD   = 2'h2;
  localparam logic [1:0] OS_RSVD   = 2'h3;

  // De-emphasis codes and one-hot outputs (all zero means off)
  localparam logic [2:0] DE_CODE_OFF = 3'h0;
  localparam logic [2:0] DE_CODE_32K = 3'h1;
  localparam logic [2:0] DE_CODE_44K = 3'h2;
  localparam logic [2:0] DE_CODE_48K = 3'h3;
  localparam logic [2:0] DE_CODE_96K = 3'h4;
  localparam logic [3:0] DE_OH_OFF   = 4'h0;
  localparam logic [3:0] DE_OH_32K   = 4'h1;
  localparam logic [3:0] DE_OH_44K   = 4'h2;
  localparam logic [3:0] DE_OH_48K   = 4'h4;
  localparam logic [3:0] DE_OH_96K   = 4'h8;

  // Zero-sample counts before silence is signalled
  localparam int         QUIET_CNT_W = 15;
  localparam logic [14:0] QUIET_N0   = 15'd3200;
  localparam logic [14:0] QUIET_N1   = 15'd4800;
  localparam logic [14:0] QUIET_N2   = 15'd9600;
  localparam logic [14:0] QUIET_N3   = 15'd19200;

  localparam int SAMPLE_W = 24;
  localparam int SYNC_LEN = 3;

  // Interrupt status bits
  localparam int IRQ_W        = 4;
  localparam int IRQ_QUIET_ON = 0;
  localparam int IRQ_QUIET_OF = 1;
  localparam int IRQ_OS_RSVD  = 2;
  localparam int IRQ_SRC_CHG  = 3;

endpackage

// >>> src/dpm_quiet_det.sv
// Purpose: Counts consecutive zero samples and flags digital silence
// Assumes: Sample strobe is on the system clock
// Notes:   Count saturates at the limit so a long silence never wraps
module dpm_quiet_det (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic [1:0] thresh_sel,
  input  wire logic       sample_valid,
  input  wire logic       sample_zero,
  output logic            quiet
);

  logic [dpm_pkg::QUIET_CNT_W-1:0] cnt_r;
  logic [dpm_pkg::QUIET_CNT_W-1:0] cnt_nxt;
  logic [dpm_pkg::QUIET_CNT_W-1:0] limit;
  logic                            quiet_r;

  assign limit = (thresh_sel == 2'h0) ? dpm_pkg::QUIET_N0 :
                 (thresh_sel == 2'h1) ? dpm_pkg::QUIET_N1 :
                 (thresh_sel == 2'h2) ? dpm_pkg::QUIET_N2 : dpm_pkg::QUIET_N3;

  // Nonzero sample or disabled detector restarts the count
  assign cnt_nxt = !enable                 ? '0 :
                   !sample_valid           ? cnt_r :
                   !sample_zero            ? '0 :
                   (cnt_r < limit)         ? cnt_r + 1'b1 : cnt_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r   <= '0;
      quiet_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      quiet_r <= enable && (cnt_nxt >= limit);
    end
  end

  assign quiet = quiet_r;

endmodule

// >>> tb/dpm_ctrl_tb.sv
// Purpose: Self-checking bench for the DAC path and mixer control block
// Assumes: One 100 MHz clock; register slave answers after one wait cycle
// Notes:   Expected read words pass through a queue to a separate watcher process
module dpm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] msk;
  } dpm_note_t;

  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        mute = 1'b0;
  logic        smp_valid = 1'b0;
  logic [23:0] smp_data = 24'h0;
  logic        pol, shp, mix_en, mix_after, bypass, atten, bass, vol, quiet, sw, irq;
  logic [2:0]  src_a, src_b;
  logic [3:0]  de_a, de_b;
  logic [1:0]  os_speed;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [31:0] lfsr = 32'h5f8cbed8;
  dpm_note_t   notes[$];

  always #5 clk_sys = ~clk_sys;

  dpm_ctrl dut (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .GLOBAL_MUTE_STATE(mute),
    .SAMPLE_VALID(smp_valid), .SAMPLE_DATA(smp_data), .OUTPUT_POLARITY_INVERT(pol),
    .SHAPER_ORDER_SELECT(shp), .MIX_ENABLE(mix_en), .MIX_AFTER_PROC(mix_after), .MIX_BYPASS(bypass),
    .MIX_SIG_ATTEN_6DB(atten), .BASS_RESONANT(bass), .CHAN_A_SOURCE(src_a), .CHAN_B_SOURCE(src_b),
    .CHAN_A_DEEMPH(de_a), .CHAN_B_DEEMPH(de_b), .OS_SPEED(os_speed), .VOLUME_ALLOWED(vol),
    .QUIET_DETECTED(quiet), .SILENCE_SWITCH(sw), .IRQ(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [3:0] src_oh(input int code);
    return (code == 0) ? 4'h1 : ((code == 2) ? 4'h4 : 4'h2);
  endfunction

  function automatic logic [3:0] de_oh(input int code);
    return (code >= 1 && code <= 4) ? 4'(1 << (code - 1)) : 4'h0;
  endfunction

  task automatic complete_run();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check_out(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t output %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_rd(input dpm_note_t n);
    n_compared++;
    if ((avs_readdata & n.msk) !== n.exp) begin
      error_cnt++;
      $display("BAD %0t read %h expected %h", $time, avs_readdata & n.msk, n.exp);
    end
  endtask

  // Read data is taken at the edge that sees waitrequest low
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      check_rd(notes.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 95000) begin
      error_cnt++;
      complete_run();
    end
  end

  // For reads d is the expected word under msk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] msk);
    @(posedge clk_sys);
    if (!wr) begin
      notes.push_back('{d & msk, msk});
    end
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wr ? d : 32'h0;
    // Only the global cycle limit ends a stuck wait
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic samples(input int n, input logic zero);
    repeat (n) begin
      @(posedge clk_sys);
      lfsr = lfsr_next(lfsr);
      smp_valid <= 1'b1;
      smp_data <= zero ? 24'h0 : (lfsr[23:0] | 24'h1);
    end
    @(posedge clk_sys);
    smp_valid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] c;
    int          lim [4];
    lim = '{3200, 4800, 9600, 19200};
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    step(1);
    check_out({pol, mix_en, atten, quiet}, 4'h0);
    check_out({3'h0, shp}, 4'h1);
    check_out({1'b0, src_a}, 4'h2);
    check_out({1'b0, src_b}, 4'h2);
    bus(1'b0, dpm_pkg::ADDR_CTRL, 32'h4d00, 32'hffff);
    bus(1'b0, 8'h30, 32'h0, 32'hffffffff);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      c = {lfsr[0], i[0], lfsr[1], 5'h0, 4'h0, lfsr[2], lfsr[3], 2'h0};
      bus(1'b1, dpm_pkg::ADDR_CTRL, {16'h0, c}, 32'h0);
      step(2);
      check_out({pol, mix_after, bass, bypass}, {c[15], c[13], c[3], c[2]});
      check_out({3'h0, shp}, {3'h0, c[14]});
      check_out({1'b0, src_a}, 4'h2);
      bus(1'b0, dpm_pkg::ADDR_CTRL, {16'h0, c}, 32'hffff);
    end
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, dpm_pkg::ADDR_CTRL, 32'h5000 | (k << 10) | (k << 8), 32'h0);
      step(3);
      check_out({1'b0, src_a}, src_oh(k));
      check_out({1'b0, src_b}, src_oh(k));
    end
    bus(1'b0, dpm_pkg::ADDR_STAT, 32'h8, 32'h8);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, dpm_pkg::ADDR_CTRL, 32'h5000 | k, 32'h0);
      step(2);
      check_out({3'h0, mix_en}, {3'h0, k == 0 || k == 3});
      check_out({1'b0, vol, os_speed}, {1'b0, k != 2, (k == 3) ? 2'h0 : 2'(k)});
    end
    bus(1'b0, dpm_pkg::ADDR_STAT, 32'h4, 32'h4);
    bus(1'b1, dpm_pkg::ADDR_CTRL, 32'h5000, 32'h0);
    for (int g = 0; g < 2; g++) begin
      bus(1'b1, dpm_pkg::ADDR_AUX, g << 6, 32'h0);
      step(2);
      check_out({3'h0, atten}, {3'h0, g == 0});
    end
    bus(1'b1, dpm_pkg::ADDR_AUX, 32'h0, 32'h0);
    bus(1'b1, dpm_pkg::ADDR_CTRL, 32'h4000, 32'h0);
    step(2);
    check_out({3'h0, atten}, 4'h0);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, dpm_pkg::ADDR_AUX, ((7 - k) << 3) | k, 32'h0);
      step(2);
      check_out(de_a, de_oh(k));
      check_out(de_b, de_oh(7 - k));
    end
    bus(1'b1, dpm_pkg::ADDR_CTRL, 32'h4080, 32'h0);
    step(2);
    check_out({3'h0, sw}, 4'h1);
    bus(1'b1, dpm_pkg::ADDR_CTRL, 32'h4000, 32'h0);
    mute <= 1'b1;
    step(8);
    check_out({3'h0, sw}, 4'h1);
    mute <= 1'b0;
    step(8);
    check_out({3'h0, sw}, 4'h0);
    bus(1'b1, dpm_pkg::ADDR_STAT, 32'hf, 32'h0);
    for (int t = 0; t < 4; t++) begin
      bus(1'b1, dpm_pkg::ADDR_MASK, (t != 1) ? 32'h1 : 32'h0, 32'h0);
      bus(1'b1, dpm_pkg::ADDR_CTRL, 32'h4040 | (t << 4), 32'h0);
      samples(lim[t] - 1, 1'b1);
      samples(1, 1'b0);
      samples(lim[t] - 1, 1'b1);
      step(3);
      check_out({3'h0, quiet}, 4'h0);
      samples(1, 1'b1);
      step(4);
      check_out({2'h0, quiet, sw}, 4'h3);
      check_out({3'h0, irq}, {3'h0, t != 1});
      bus(1'b0, dpm_pkg::ADDR_INFO, 32'h100, 32'h100);
      bus(1'b1, dpm_pkg::ADDR_STAT, 32'hf, 32'h0);
      step(2);
      check_out({3'h0, irq}, 4'h0);
      samples(1, 1'b0);
      step(3);
      check_out({3'h0, quiet}, 4'h0);
    end
    bus(1'b1, dpm_pkg::ADDR_CTRL, 32'h4000, 32'h0);
    samples(3200, 1'b1);
    step(3);
    check_out({3'h0, quiet}, 4'h0);
    complete_run();
  end
endmodule
